// [rtl/ir_remote_cfg.svh]
/*
  Constants of the infrared remote unit: register indexes, fields,
  reset values and bus codes. Assumes byte address = index * 4.
*/
// Function
// - Direction bit zero transmits, one receives
// - Enable starts operation, clearing it stops
// - Level bit gates carrier onto transmit pin
// - Counter loads on write, decrements, underflows once
// - Enable in receive mode starts edge detection
// - Receive pin sampled on carrier clock tick
// - Edge needs new level on two ticks
// - Receive mode level bit shows received level
// - Receive mode counter underflow also flagged
// - One interrupt request shared by three causes
// - Underflow sets flag bit zero
// - Underflow enable zero blocks its flag
// - Rising receive edge sets flag bit one
// - Falling receive edge sets flag bit two
// - Edge enables zero block their flags
// - Writing one clears a flag
// - Request active while any flag set
// - Config bits: enable bit0, direction bit1
`ifndef IR_REMOTE_CFG_SVH
`define IR_REMOTE_CFG_SVH
`define IR_ADDR_W      18
`define IR_IDX_CONFIG  16'h5340
`define IR_IDX_PRESCL  16'h5341
`define IR_IDX_LEVEL   16'h5344
`define IR_IDX_COUNT   16'h5345
`define IR_IDX_MASK    16'h5346
`define IR_IDX_FLAGS   16'h5347
`define IR_BIT_EN      0
`define IR_BIT_DIR     1
`define IR_BIT_UNDER   0
`define IR_BIT_RISE    1
`define IR_BIT_FALL    2
`define IR_RST_BYTE    8'h00
`define IR_RST_MASK    3'h0
`define IR_SEL_OFF     4'hf
`define IR_RESP_OKAY   2'h0
`define IR_RESP_SLVERR 2'h2
`endif

// [rtl/ir_remote_pkg.sv]
/*
  Types shared by the infrared remote unit.
  Assumes ir_remote_cfg.svh is compiled alongside.
*/
package ir_remote_pkg;
  // Operating state, one-hot.
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_TX  = 3'b010,
    ST_RX  = 3'b100
  } mode_e;
  // Prescaler taps, bit n pulses at clock/2**n.
  typedef logic [14:0] taps_t;
  // Interrupt causes in flag order.
  typedef struct packed {
    logic fall;
    logic rise;
    logic under;
  } cause_s;
endpackage : ir_remote_pkg

// [rtl/ir_tick_select.sv]
/*
  Selects one prescaler tap as a count or sample tick.
  Assumes each tap is a one-cycle pulse on aclk.
*/
`timescale 1ns/100ps
`include "ir_remote_cfg.svh"
module ir_tick_select (
  input  wire ir_remote_pkg::taps_t taps,
  input  wire logic [3:0]           sel,
  output logic                      tick
);
  import ir_remote_pkg::*;
  // The reserved code yields no tick, so the consumer stalls.
  assign tick = (sel == `IR_SEL_OFF) ? 1'b0 : taps[sel];
endmodule // ir_tick_select

// [rtl/ir_edge_filter.sv]
/*
  Noise filter and edge detector for the receive pin.
  Assumes the pin is already synchronous to aclk.
*/
`timescale 1ns/100ps
`include "ir_remote_cfg.svh"
module ir_edge_filter (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic tick,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import ir_remote_pkg::*;
  logic prev_r;
  logic level_r;
  logic rise_r;
  logic fall_r;
  wire  agree = tick & (pin == prev_r) & (pin != level_r);
  // While idle the filter tracks the pin, so enabling never fakes an edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r  <= 1'b0;
      level_r <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else if (!run) begin
      prev_r  <= pin;
      level_r <= pin;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      if (tick) prev_r <= pin;
      if (agree) level_r <= pin;
      rise_r <= agree & pin;
      fall_r <= agree & ~pin;
    end
  end
  assign level = level_r;
  assign rise  = rise_r;
  assign fall  = fall_r;
endmodule // ir_edge_filter

// [rtl/ir_remote_unit.sv]
/*
  Infrared remote unit: AXI4-Lite registers, pulse length counter,
  carrier gating on transmit and filtered edge capture on receive.
  Assumes carrier and prescaler taps come from outside on aclk,
  and the receive pin is synchronous to aclk.
*/
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`include "ir_remote_cfg.svh"
module ir_remote_unit (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`IR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`IR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire ir_remote_pkg::taps_t  prescale_taps,
  input  wire logic                  carrier_in,
  input  wire logic                  ir_receive_pin,
  output logic                       ir_transmit_pin,
  output logic                       irq
);
  import ir_remote_pkg::*;

  // ==========================================================
  // Write channel
  // ==========================================================
  logic                  aw_got_r;
  logic                  w_got_r;
  logic [`IR_ADDR_W-1:0] awaddr_r;
  logic [7:0]            wbyte_r;
  logic                  wlane_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;

  // Address and data are taken independently, then answered together.
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_got_r & w_got_r & ~bvalid_r;

  // Write decode on the word index.
  wire [15:0] widx   = awaddr_r[`IR_ADDR_W-1:2];
  wire        wr_en  = do_write & wlane_r;
  wire        wr_cfg = wr_en & (widx == `IR_IDX_CONFIG);
  wire        wr_psc = wr_en & (widx == `IR_IDX_PRESCL);
  wire        wr_lvl = wr_en & (widx == `IR_IDX_LEVEL);
  wire        wr_cnt = wr_en & (widx == `IR_IDX_COUNT);
  wire        wr_msk = wr_en & (widx == `IR_IDX_MASK);
  wire        wr_flg = wr_en & (widx == `IR_IDX_FLAGS);
  wire        w_hit  = (widx == `IR_IDX_CONFIG) | (widx == `IR_IDX_PRESCL)
                     | ((widx >= `IR_IDX_LEVEL) & (widx <= `IR_IDX_FLAGS));

  // Capture of the two write channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wbyte_r  <= `IR_RST_BYTE;
      wlane_r  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got_r <= 1'b0;
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `IR_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_hit ? `IR_RESP_OKAY : `IR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ==========================================================
  // Control registers
  // ==========================================================
  logic [1:0] cfg_r;
  logic [7:0] psc_r;
  logic       level_r;
  logic [2:0] mask_r;
  mode_e      mode_r;
  mode_e      mode_nxt;

  // Configuration, clock selects, level bit and enables.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r   <= 2'h0;
      psc_r   <= `IR_RST_BYTE;
      level_r <= 1'b0;
      mask_r  <= `IR_RST_MASK;
    end else begin
      if (wr_cfg) cfg_r <= {wbyte_r[`IR_BIT_DIR], wbyte_r[`IR_BIT_EN]};
      if (wr_psc) psc_r <= wbyte_r;
      if (wr_lvl) level_r <= wbyte_r[0];
      if (wr_msk) mask_r <= wbyte_r[2:0];
    end
  end

  // Operating state follows the enable and direction bits.
  always_comb begin
    case ({cfg_r[1], cfg_r[0]})
      2'b01:   mode_nxt = ST_TX;
      2'b11:   mode_nxt = ST_RX;
      2'b00:   mode_nxt = ST_OFF;
      2'b10:   mode_nxt = ST_OFF;
      default: mode_nxt = ST_OFF;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) mode_r <= ST_OFF;
    else          mode_r <= mode_nxt;
  end
  wire running = (mode_r != ST_OFF);
  wire rx_mode = (mode_r == ST_RX);

  // ==========================================================
  // Ticks, receive filter and length counter
  // ==========================================================
  logic cg_tick;
  logic lc_tick;
  logic rx_level;
  logic rx_rise;
  logic rx_fall;

  ir_tick_select u_cg_sel (
    .taps (prescale_taps),
    .sel  (psc_r[7:4]),
    .tick (cg_tick)
  );
  ir_tick_select u_lc_sel (
    .taps (prescale_taps),
    .sel  (psc_r[3:0]),
    .tick (lc_tick)
  );
  ir_edge_filter u_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (rx_mode),
    .tick    (cg_tick),
    .pin     (ir_receive_pin),
    .level   (rx_level),
    .rise    (rx_rise),
    .fall    (rx_fall)
  );

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  // A load beats a tick in the same cycle; the counter parks at zero.
  wire count_step = running & lc_tick & (count_r != 8'h00) & ~wr_cnt;
  wire under_hit  = count_step & (count_r == 8'h01);

  assign count_nxt = wr_cnt     ? wbyte_r
                   : count_step ? count_r - 8'h01 : count_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) count_r <= `IR_RST_BYTE;
    else          count_r <= count_nxt;
  end

  // ==========================================================
  // Interrupt flags
  // ==========================================================
  cause_s flags_r;
  cause_s flags_nxt;
  cause_s set_v;
  cause_s clr_v;
  // Each cause is dropped while its enable is low.
  assign set_v.under = under_hit & mask_r[`IR_BIT_UNDER];
  assign set_v.rise  = rx_rise & mask_r[`IR_BIT_RISE];
  assign set_v.fall  = rx_fall & mask_r[`IR_BIT_FALL];
  assign clr_v       = wr_flg ? cause_s'(wbyte_r[2:0]) : cause_s'(3'h0);
  // A new event beats a clear landing in the same cycle.
  assign flags_nxt   = cause_s'((flags_r & ~clr_v) | set_v);
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_r <= cause_s'(`IR_RST_MASK);
    else          flags_r <= flags_nxt;
  end
  assign irq = |flags_r;

  // ==========================================================
  // Transmit output
  // ==========================================================
  logic tx_r;
  // Registered so the pin never glitches on decode changes.
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_r <= 1'b0;
    else          tx_r <= (mode_r == ST_TX) & level_r & carrier_in;
  end
  assign ir_transmit_pin = tx_r;

  // ==========================================================
  // Read channel
  // ==========================================================
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  rbyte;
  logic        r_hit;
  wire  [15:0] ridx = s_axi_araddr[`IR_ADDR_W-1:2];
  wire         lvl_view = rx_mode ? rx_level : level_r;

  always_comb begin
    r_hit = 1'b1;
    case (ridx)
      `IR_IDX_CONFIG: rbyte = {6'h00, cfg_r};
      `IR_IDX_PRESCL: rbyte = psc_r;
      `IR_IDX_LEVEL:  rbyte = {7'h00, lvl_view};
      `IR_IDX_COUNT:  rbyte = count_r;
      `IR_IDX_MASK:   rbyte = {5'h00, mask_r};
      `IR_IDX_FLAGS:  rbyte = {5'h00, flags_r};
      default: begin
        rbyte = 8'h00;
        r_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `IR_RESP_OKAY;
    end else if (s_axi_arvalid & ~rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rbyte};
      rresp_r  <= r_hit ? `IR_RESP_OKAY : `IR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_mode_follow_cfg: assert property (
    cfg_r == 2'b11 |=> mode_r == ST_RX
  ) else $error("Receive mode not entered");
  chk_stop_clears_mode: assert property (
    wr_cfg && !wbyte_r[0] |=> ##1 mode_r == ST_OFF
  ) else $error("Unit did not stop");
  chk_tx_pin_gate: assert property (
    mode_r == ST_TX && level_r && carrier_in |=> ir_transmit_pin
  ) else $error("Transmit pin not driven");
  chk_idle_pin_low: assert property (
    mode_r == ST_OFF |=> !ir_transmit_pin
  ) else $error("Transmit pin active while off");
  chk_count_hold: assert property (
    mode_r == ST_OFF && !wr_cnt |=> $stable(count_r)
  ) else $error("Counter moved while off");
  chk_count_load: assert property (
    wr_cnt |=> count_r == $past(wbyte_r)
  ) else $error("Counter load lost");
  chk_under_flag: assert property (
    under_hit && mask_r[0] |=> flags_r.under && count_r == 8'h00
  ) else $error("Underflow flag missing");
  chk_under_masked: assert property (
    !mask_r[0] && !flags_r.under |=> !flags_r.under
  ) else $error("Masked underflow flag set");
  chk_rise_flag: assert property (
    rx_rise && mask_r[1] |=> flags_r.rise
  ) else $error("Rise flag missing");
  chk_fall_flag: assert property (
    rx_fall && mask_r[2] |=> flags_r.fall
  ) else $error("Fall flag missing");
  chk_flag_clear: assert property (
    wr_flg && wbyte_r[1] && !set_v.rise |=> !flags_r.rise
  ) else $error("Flag not cleared");
  chk_irq_any: assert property (
    irq == (flags_r != 3'h0)
  ) else $error("Request disagrees with flags");
  chk_edge_filter: assert property (
    rx_rise |-> $past(rx_level, 1) == 1'b0 && rx_level
  ) else $error("Edge without level change");

  // Apart from a load, the counter moves only on its own tick, and then by exactly one.
  // Holding on a missing tick matters: the reserved select code relies on it.
  chk_count_tick_hold: assert property (
    !lc_tick && !wr_cnt |=> $stable(count_r)
  ) else $error("Counter moved without a tick");
  chk_count_step: assert property (
    running && lc_tick && count_r != 8'h00 && !wr_cnt |=> count_r == $past(count_r) - 8'h01
  ) else $error("Counter missed a step");

  // Edge causes stay quiet while their enables are low.
  chk_rise_masked: assert property (
    !mask_r[`IR_BIT_RISE] && !flags_r.rise |=> !flags_r.rise
  ) else $error("Masked rise flag set");
  chk_fall_masked: assert property (
    !mask_r[`IR_BIT_FALL] && !flags_r.fall |=> !flags_r.fall
  ) else $error("Masked fall flag set");

  // Receive mode never drives the emitter, and edges come only from reception.
  chk_rx_tx_quiet: assert property (
    mode_r == ST_RX |=> !ir_transmit_pin
  ) else $error("Transmit pin active in receive mode");
  chk_edge_rx_only: assert property (
    rx_rise || rx_fall |-> $past(rx_mode)
  ) else $error("Edge reported outside reception");

  // Answers on the register bus stand until the master takes them.
  chk_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("Write response dropped early");
  chk_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("Read data dropped early");
endmodule // ir_remote_unit

// [test/ir_link_model.sv]
/*
  Far side of the infrared link: a receiver module that drives the
  receive pin. Assumes the bench commands the level and any glitch.
*/
`timescale 1ns/100ps
module ir_link_model (
  input  wire logic aclk,
  input  wire logic lvl,
  input  wire logic glt,
  output logic      ir_receive_pin
);
  // ==========================================================
  // Receiver output
  // A real receiver is push-pull, so the pin always shows a level.
  // A glitch inverts one cycle to look like optical noise.
  always_ff @(posedge aclk) begin
    ir_receive_pin <= lvl ^ glt;
  end
endmodule // ir_link_model

// [test/test_infrared_remote_txrx_control.sv]
/*
  Self-checking bench of the infrared remote unit over AXI4-Lite.
  Assumes the design header and package are compiled first.
*/
`timescale 1ns/100ps
`include "ir_remote_cfg.svh"
module test_infrared_remote_txrx_control;
  import ir_remote_pkg::*;
  typedef struct packed {
    logic w; logic [17:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;
  } row_s;
  logic aclk = 0, aresetn = 0, carrier_in = 0, lvl = 0, glt = 0;
  logic [17:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rd_v;
  logic [14:0] pcnt = 0;
  taps_t taps;
  int fails = 0, num_checks = 0, cycles = 0;
  row_s rows[13];
  // ==========================================================
  // Clock, prescaler taps and time limit
  always #5 aclk = ~aclk;
  always @(posedge aclk) pcnt <= pcnt + 15'h1;
  // Tap n pulses once every 2**n cycles, as the prescaler would.
  always_comb for (int n = 0; n < 15; n++) taps[n] = ((pcnt & ((15'h1 << n) - 15'h1)) == 15'h0);
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      $display("[ERR] cycles expected below %0d seen %0d", 20000, cycles);
      fails++;
      complete_run();
    end
  end
  ir_link_model far (.aclk(aclk), .lvl(lvl), .glt(glt), .ir_receive_pin(rx_pin));
  ir_remote_unit uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .prescale_taps(taps),
    .carrier_in(carrier_in), .ir_receive_pin(rx_pin), .ir_transmit_pin(tx_pin), .irq(irq));
  // ==========================================================
  // Bus and check tasks
  // Handshakes are judged at the falling edge, so the rising edge acts on settled values.
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic ka, kw, kb;
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge aclk);
      ka = awvalid && awready; kw = wvalid && wready; kb = bvalid; rs = bresp;
      @(posedge aclk);
      if (ka) awvalid <= 0;
      if (kw) wvalid <= 0;
      t++;
    end while (!kb && t < 100);
    if (!kb) begin
      $display("[ERR] write response expected 1 seen 0");
      fails++;
    end
    bready <= 0;
  endtask
  task automatic rd(input logic [17:0] a);
    logic ka, kr;
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge aclk);
      ka = arvalid && arready; kr = rvalid; rd_v = rdata; rs = rresp;
      @(posedge aclk);
      if (ka) arvalid <= 0;
      t++;
    end while (!kr && t < 100);
    if (!kr) begin
      $display("[ERR] read data expected 1 seen 0");
      fails++;
    end
    rready <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic rdc(input string nm, input logic [17:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, {24'h0, e}, rd_v);
  endtask
  // Ends on a falling edge so that the caller sees settled outputs.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic drive_rx(input logic v, input logic g);
    @(posedge aclk);
    lvl <= v; glt <= g;
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rows = '{
      '{0, 18'h14d00, 8'h00, 8'h00, 2'h0}, '{0, 18'h14d10, 8'h00, 8'h00, 2'h0},
      '{0, 18'h14d04, 8'h00, 8'h00, 2'h0},
      '{0, 18'h14d14, 8'h00, 8'h00, 2'h0}, '{0, 18'h14d18, 8'h00, 8'h00, 2'h0},
      '{0, 18'h14d1c, 8'h00, 8'h00, 2'h0}, '{1, 18'h14d18, 8'h07, 8'h00, 2'h0},
      '{0, 18'h14d18, 8'h00, 8'h07, 2'h0}, '{1, 18'h14d00, 8'h02, 8'h00, 2'h0},
      '{0, 18'h14d00, 8'h00, 8'h02, 2'h0}, '{1, 18'h14d08, 8'h55, 8'h00, 2'h2},
      '{0, 18'h14d08, 8'h00, 8'h00, 2'h2}, '{1, 18'h14d00, 8'h00, 8'h00, 2'h0}};
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    // Reset values, field access and the unmapped hole.
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a);
        chk("row data", {24'h0, rows[i].e}, rd_v);
      end
      chk("row resp", {30'h0, rows[i].r}, {30'h0, rs});
    end
    // Transmit: level zero and count zero before enabling.
    wr(18'h14d18, 8'h01); wr(18'h14d04, 8'h01); wr(18'h14d10, 8'h00); wr(18'h14d14, 8'h00);
    carrier_in <= 1;
    wr(18'h14d00, 8'h01);
    wait_cyc(3);
    chk("tx low", 0, tx_pin);
    wr(18'h14d10, 8'h01); wait_cyc(3);
    chk("tx high", 1, tx_pin);
    @(posedge aclk) carrier_in <= 0;
    wait_cyc(3);
    chk("tx gated", 0, tx_pin);
    @(posedge aclk) carrier_in <= 1;
    wr(18'h14d14, 8'h08); wait_cyc(4);
    chk("irq early", 0, irq);
    wait_cyc(30);
    chk("irq under", 1, irq);
    rdc("flags", 18'h14d1c, 8'h01);
    rdc("count end", 18'h14d14, 8'h00);
    wr(18'h14d1c, 8'h01); wait_cyc(2);
    chk("irq clear", 0, irq);
    wr(18'h14d00, 8'h00); wait_cyc(3);
    chk("tx off", 0, tx_pin);
    wr(18'h14d14, 8'h05); wait_cyc(20);
    rdc("count hold", 18'h14d14, 8'h05);
    // The reserved tick code stalls the counter even while enabled.
    wr(18'h14d04, 8'h0f); wr(18'h14d00, 8'h01); wait_cyc(20);
    rdc("no tick", 18'h14d14, 8'h05);
    wr(18'h14d00, 8'h00); wr(18'h14d04, 8'h01);
    // Underflow with its enable clear leaves the flag alone.
    wr(18'h14d18, 8'h00); wr(18'h14d00, 8'h01); wait_cyc(30);
    rdc("masked", 18'h14d1c, 8'h00);
    wr(18'h14d00, 8'h00); wr(18'h14d04, 8'h00);
    // Receive: edges, noise and end-of-frame underflow.
    wr(18'h14d18, 8'h06); wr(18'h14d00, 8'h03); wait_cyc(5);
    drive_rx(1, 0); wait_cyc(8);
    rdc("rise", 18'h14d1c, 8'h02);
    wait_cyc(0); chk("irq rise", 1, irq);
    rdc("rx level", 18'h14d10, 8'h01);
    wr(18'h14d1c, 8'h02); wr(18'h14d14, 8'hff);
    drive_rx(1, 1); drive_rx(1, 0); wait_cyc(8);
    rdc("noise", 18'h14d1c, 8'h00);
    drive_rx(0, 0); wait_cyc(8);
    rdc("fall", 18'h14d1c, 8'h04);
    wr(18'h14d1c, 8'h04); wr(18'h14d00, 8'h00); wr(18'h14d18, 8'h01);
    wr(18'h14d00, 8'h03); wr(18'h14d14, 8'h04); wait_cyc(20);
    rdc("rx under", 18'h14d1c, 8'h01);
    wr(18'h14d1c, 8'h07); drive_rx(1, 0); wait_cyc(8);
    rdc("edge mask", 18'h14d1c, 8'h00);
    wait_cyc(0); chk("irq idle", 0, irq);
    wr(18'h14d00, 8'h00);
    // A reset in mid-run, with the unit transmitting, restores config, count and flags and drops the pin and request.
    wr(18'h14d14, 8'h09); wr(18'h14d00, 8'h01);
    @(posedge aclk) aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rdc("reset cfg", 18'h14d00, 8'h00);
    rdc("reset count", 18'h14d14, 8'h00);
    rdc("reset flags", 18'h14d1c, 8'h00);
    wait_cyc(0); chk("reset tx", 0, tx_pin);
    chk("reset irq", 0, irq);
    complete_run();
  end
endmodule // test_infrared_remote_txrx_control
